// ### hdl/fsw_status.sv
/*
  status word logic of a parallel flash: command decode for the status
  path, the 8-bit status word, and the read path for asynchronous and
  synchronous burst reads.
  assumes the program, erase and lock engines report through the
  event inputs below, all on ref_clk_in; bus pins are asynchronous.
*/
`timescale 1ns/1ps
// Summary of operation
// - read-status command at any address selects status
// - program, erase, lock sequences enter status output
// - status on low byte, zeros on high byte
// - async read latches status on ce fall with oe high or oe fall with ce low
// - page reads after first word are undefined
// - burst repeats same status word for burst length
// - bit 7 low while busy unless sequence error, high when ready
// - bits 6 and 2 show erase/program suspend
// - bits 5:4 encode result or sequence error
// - reported program or erase error aborts operation
// - bit 3 set on low programming voltage
// - bit 1 set and abort on locked block
// - bit 0 high while factory buffer loading
// - status default is 0x80
// - sequence error in suspend sets 7,5,4 sticky
// - clear-status works regardless of supply level
// - 7,6,2 follow device; 5,4,3,1 sticky
// - reset returns status to default
// - erase resume clears bit 6
// - bad command after lock setup gives sequence error
module fsw_status
  import fsw_pkg::*;
(
  input wire logic ref_clk_in, // 25 MHz block clock
  input wire logic reset_n_in, // synchronous reset, active low
  input wire logic chip_enable_n_in, // bus chip enable pin
  input wire logic output_enable_n_in, // bus output enable pin
  input wire logic write_enable_n_in, // bus write enable pin
  input wire logic address_valid_n_in, // bus address valid pin
  input wire logic link_clk_in, // burst clock pin, sampled
  input wire logic [15:0] dq_in, // data bus input
  input wire logic sync_mode_in, // 1 = synchronous burst reads
  input wire logic [2:0] burst_len_in, // burst length code
  input wire logic [15:0] array_data_in, // array word for array reads
  input wire logic busy_in, // program or erase running
  input wire logic erase_susp_in, // erase suspended or pending
  input wire logic prog_susp_in, // program suspended or pending
  input wire logic prog_err_in, // pulse: program failed
  input wire logic erase_err_in, // pulse: erase or blank check failed
  input wire logic vpp_low_in, // pulse: supply below lockout level
  input wire logic locked_hit_in, // pulse: operation hit locked block
  input wire logic factory_load_in, // factory buffer still loading
  output logic [15:0] dq_out, // data bus output
  output logic dq_oe_out, // data bus output enable
  output logic [7:0] flash_status_word_out, // current status word
  output logic abort_out, // pulse: abort running operation
  output logic erase_resume_out // pulse: erase resume written
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic ce_n, ce_n_prev, oe_n, oe_n_prev, we_n, we_n_prev;
  logic adv_n, adv_n_prev, lclk, lclk_prev;

  fsw_sync u_ce (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .pin_in(chip_enable_n_in), .init_in(1'b1), .level_out(ce_n), .prev_out(ce_n_prev));
  fsw_sync u_oe (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .pin_in(output_enable_n_in), .init_in(1'b1), .level_out(oe_n), .prev_out(oe_n_prev));
  fsw_sync u_we (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .pin_in(write_enable_n_in), .init_in(1'b1), .level_out(we_n), .prev_out(we_n_prev));
  fsw_sync u_adv (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .pin_in(address_valid_n_in), .init_in(1'b1), .level_out(adv_n),
    .prev_out(adv_n_prev));
  // link clock parks low, so its synchroniser resets low
  fsw_sync u_lclk (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .pin_in(link_clk_in), .init_in(1'b0), .level_out(lclk), .prev_out(lclk_prev));

  // low data byte passes two flops as well; sampled every clock, used on the write edge
  logic [7:0] dq_s1, dq_s2;
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= dq_in[7:0];
      dq_s2 <= dq_s1;
    end
  end

  logic ce_fall, oe_fall, adv_fall, we_rise, lclk_rise, read_on;
  assign ce_fall = ce_n_prev & ~ce_n;
  assign oe_fall = oe_n_prev & ~oe_n;
  assign adv_fall = adv_n_prev & ~adv_n;
  assign we_rise = ~we_n_prev & we_n & ~ce_n;
  assign lclk_rise = ~lclk_prev & lclk;
  assign read_on = ~ce_n & ~oe_n;

  ////////////////////////////////////////////////////////////////////
  // command decode
  fsw_mode_type mode;
  logic lock_setup, erase_setup, prog_setup, cfg_setup;
  logic cmd_clear, cmd_seq_err, cmd_resume;
  logic [7:0] cmd;
  assign cmd = dq_s2;

  // combinational classification of the written byte
  always_comb begin
    cmd_clear = 1'b0;
    cmd_seq_err = 1'b0;
    cmd_resume = 1'b0;
    if (we_rise) begin
      if (lock_setup) begin
        cmd_seq_err = (cmd != FSW_CMD_LOCK) && (cmd != FSW_CMD_CONFIRM) &&
                      (cmd != FSW_CMD_LOCK_DOWN) && (cmd != FSW_CMD_CFG_SETUP);
      end else if (erase_setup) begin
        cmd_seq_err = (cmd != FSW_CMD_CONFIRM);
      end else if (!prog_setup && !cfg_setup) begin
        cmd_clear = (cmd == FSW_CMD_CLEAR_STATUS);
        cmd_resume = (cmd == FSW_CMD_CONFIRM) && erase_susp_in;
      end
    end
  end

  // mode and pending second-cycle tracking
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      mode <= FSW_MODE_ARRAY;
      lock_setup <= 1'b0;
      erase_setup <= 1'b0;
      prog_setup <= 1'b0;
      cfg_setup <= 1'b0;
    end else if (we_rise) begin
      lock_setup <= 1'b0;
      erase_setup <= 1'b0;
      prog_setup <= 1'b0;
      cfg_setup <= 1'b0;
      if (prog_setup || erase_setup || lock_setup) begin
        mode <= FSW_MODE_STATUS;
      end else if (cfg_setup) begin
        mode <= FSW_MODE_ARRAY;
      end else begin
        case (cmd)
          FSW_CMD_READ_STATUS: mode <= FSW_MODE_STATUS;
          FSW_CMD_READ_ARRAY: mode <= FSW_MODE_ARRAY;
          FSW_CMD_READ_ID: mode <= FSW_MODE_OTHER;
          FSW_CMD_WORD_PROG: prog_setup <= 1'b1;
          FSW_CMD_ERASE_SETUP: erase_setup <= 1'b1;
          FSW_CMD_LOCK_SETUP: lock_setup <= 1'b1;
          FSW_CMD_CFG_SETUP: cfg_setup <= 1'b1;
          FSW_CMD_SUSPEND, FSW_CMD_CONFIRM: mode <= FSW_MODE_STATUS;
          default: mode <= mode;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status word; bits 7,6,2,0 follow the engine, the rest are sticky
  logic [1:0] result;
  logic vpp_flag, locked_flag;
  logic [7:0] status_now;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      result <= FSW_STATUS_RESET[FSW_BIT_ERASE_ERR:FSW_BIT_PROG_ERR];
      vpp_flag <= FSW_STATUS_RESET[FSW_BIT_VPP];
      locked_flag <= FSW_STATUS_RESET[FSW_BIT_LOCKED];
    end else begin
      // set wins over a clear in the same cycle
      result <= (cmd_clear ? FSW_RES_OK : result) |
                (cmd_seq_err ? FSW_RES_SEQ : FSW_RES_OK) |
                (prog_err_in ? FSW_RES_PROG : FSW_RES_OK) |
                (erase_err_in ? FSW_RES_ERASE : FSW_RES_OK);
      vpp_flag <= (vpp_flag & ~cmd_clear) | vpp_low_in;
      locked_flag <= (locked_flag & ~cmd_clear) | locked_hit_in;
    end
  end

  // a sequence error forces ready so bits 7,5,4 read set together
  assign status_now = {~busy_in | (result == FSW_RES_SEQ),
                       erase_susp_in & ~cmd_resume,
                       result, vpp_flag, prog_susp_in, locked_flag,
                       factory_load_in};

  // abort engine on any reported failure
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      abort_out <= 1'b0;
      erase_resume_out <= 1'b0;
      flash_status_word_out <= FSW_STATUS_RESET;
    end else begin
      abort_out <= prog_err_in | erase_err_in | vpp_low_in | locked_hit_in;
      erase_resume_out <= cmd_resume;
      flash_status_word_out <= status_now;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read path: latched status, burst repetition
  logic [7:0] status_latch;
  logic [4:0] burst_cnt, burst_len;
  logic burst_live, page_first;

  always_comb begin
    case (burst_len_in)
      FSW_BL_4: burst_len = FSW_LEN_4;
      FSW_BL_8: burst_len = FSW_LEN_8;
      FSW_BL_16: burst_len = FSW_LEN_16;
      default: burst_len = 5'h1F; // code 7 repeats until ce rises; other codes end after 31 clocks
    endcase
  end

  // latch only on access start; stale data is the host's problem
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      status_latch <= FSW_STATUS_RESET;
    end else if (sync_mode_in ? (ce_fall | adv_fall) : ((ce_fall & oe_n) | (oe_fall & ~ce_n) |
                 (ce_fall & oe_fall))) begin
      status_latch <= status_now;
    end
  end

  // burst counter runs on sampled link clock edges
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      burst_cnt <= 5'h00;
      burst_live <= 1'b0;
      page_first <= 1'b0;
    end else begin
      page_first <= read_on & (oe_fall | ce_fall | page_first);
      if (ce_fall | adv_fall) begin
        burst_cnt <= 5'h00;
        burst_live <= sync_mode_in;
      end else if (ce_n) begin
        burst_live <= 1'b0;
      end else if (burst_live && lclk_rise) begin
        if (burst_len_in != 3'h7 && burst_cnt == burst_len - 5'h01) begin
          burst_live <= 1'b0;
        end else begin
          burst_cnt <= burst_cnt + 5'h01;
        end
      end
    end
  end

  // drive the bus; page words after the first repeat the latch,
  // which is one of the allowed undefined values
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
    end else begin
      dq_oe_out <= read_on;
      if (mode == FSW_MODE_STATUS) begin
        dq_out <= {FSW_UPPER_BYTE, status_latch};
      end else begin
        dq_out <= array_data_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  reset_default_a: assert property (@(posedge ref_clk_in)
    $rose(reset_n_in) |-> flash_status_word_out == FSW_STATUS_RESET)
    else $error("status not default after reset");
  upper_zero_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (dq_oe_out && $past(mode) == FSW_MODE_STATUS) |-> dq_out[15:8] == 8'h00)
    else $error("upper byte not zero in status read");
  sticky_vpp_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (vpp_flag && !cmd_clear) |=> vpp_flag)
    else $error("voltage flag dropped without clear");
  vpp_set_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    vpp_low_in |=> ##1 flash_status_word_out[FSW_BIT_VPP])
    else $error("voltage fault not reported");
  lock_abort_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    locked_hit_in |=> abort_out && locked_flag)
    else $error("locked block not aborted");
  seq_err_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    cmd_seq_err |=> ##1 (flash_status_word_out[7:4] & 4'hB) == 4'hB)
    else $error("sequence error bits not set");
  busy_bit_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (busy_in && result != FSW_RES_SEQ) |=> !flash_status_word_out[FSW_BIT_READY])
    else $error("ready shown while busy");
  clear_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (cmd_clear && !vpp_low_in && !locked_hit_in && !cmd_seq_err &&
     !prog_err_in && !erase_err_in) |=> result == FSW_RES_OK && !vpp_flag && !locked_flag)
    else $error("clear status failed");
  status_mode_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (we_rise && !prog_setup && !erase_setup && !lock_setup && !cfg_setup &&
     cmd == FSW_CMD_READ_STATUS) |=> mode == FSW_MODE_STATUS)
    else $error("read status not entered");
  // later words of an asynchronous access must not relatch the status
  page_hold_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (page_first && !sync_mode_in) |=> $stable(status_latch))
    else $error("page word relatched status");
  // inside a burst only a new enable or address valid fall may relatch
  burst_rep_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (burst_live && sync_mode_in && !ce_fall && !adv_fall) |=> $stable(status_latch))
    else $error("burst word changed mid burst");
endmodule

// ### inc/fsw_pkg.sv
/*
  package for the flash status word block: command codes, status bit
  positions, reset values, synchroniser depth and burst length codes.
  assumes a single 25 MHz clock domain and 16-bit flash data bus.
*/
package fsw_pkg;
  // command codes written on the low data byte
  localparam logic [7:0] FSW_CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] FSW_CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] FSW_CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FSW_CMD_WORD_PROG = 8'h40;
  localparam logic [7:0] FSW_CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] FSW_CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] FSW_CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] FSW_CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] FSW_CMD_LOCK = 8'h01;
  localparam logic [7:0] FSW_CMD_LOCK_DOWN = 8'h2F;
  localparam logic [7:0] FSW_CMD_READ_ID = 8'h90;
  localparam logic [7:0] FSW_CMD_CFG_SETUP = 8'h03;
  // status word bit positions
  localparam int FSW_BIT_READY = 7;
  localparam int FSW_BIT_ERS_SUSP = 6;
  localparam int FSW_BIT_ERASE_ERR = 5;
  localparam int FSW_BIT_PROG_ERR = 4;
  localparam int FSW_BIT_VPP = 3;
  localparam int FSW_BIT_PRG_SUSP = 2;
  localparam int FSW_BIT_LOCKED = 1;
  localparam int FSW_BIT_FACTORY = 0;
  // result field encodings in bits 5:4
  localparam logic [1:0] FSW_RES_OK = 2'h0;
  localparam logic [1:0] FSW_RES_PROG = 2'h1;
  localparam logic [1:0] FSW_RES_ERASE = 2'h2;
  localparam logic [1:0] FSW_RES_SEQ = 2'h3;
  // reset values
  localparam logic [7:0] FSW_STATUS_RESET = 8'h80;
  localparam logic [7:0] FSW_UPPER_BYTE = 8'h00;
  // synchroniser depth and burst length codes
  localparam int FSW_SYNC_STAGES = 2;
  localparam logic [2:0] FSW_BL_4 = 3'h1;
  localparam logic [2:0] FSW_BL_8 = 3'h2;
  localparam logic [2:0] FSW_BL_16 = 3'h3;
  localparam logic [4:0] FSW_LEN_4 = 5'h04;
  localparam logic [4:0] FSW_LEN_8 = 5'h08;
  localparam logic [4:0] FSW_LEN_16 = 5'h10;
  // bus modes seen by the read path
  typedef enum logic [1:0] {
    FSW_MODE_ARRAY = 2'b00,
    FSW_MODE_STATUS = 2'b01,
    FSW_MODE_OTHER = 2'b11
  } fsw_mode_type;
endpackage

// ### hdl/fsw_sync.sv
/*
  two-stage synchroniser for one pin, with a registered copy so edges
  can be found without touching the first stage.
  assumes the pin is asynchronous to ref_clk_in.
*/
`timescale 1ns/1ps
module fsw_sync
  import fsw_pkg::*;
(
  input wire logic ref_clk_in, // block clock
  input wire logic reset_n_in, // synchronous reset, active low
  input wire logic pin_in, // raw pin level
  input wire logic init_in, // level taken during reset
  output logic level_out, // synchronised level
  output logic prev_out // synchronised level one cycle ago
);
  logic [FSW_SYNC_STAGES-1:0] stage;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      stage <= {FSW_SYNC_STAGES{init_in}}; // idle level, so no false edge
      prev_out <= init_in;
    end else begin
      stage <= {stage[FSW_SYNC_STAGES-2:0], pin_in};
      prev_out <= stage[FSW_SYNC_STAGES-1];
    end
  end

  assign level_out = stage[FSW_SYNC_STAGES-1];
endmodule

// ### verification/fsw_host_model.sv
/*
  host controller model: drives the flash bus pins with write, single
  asynchronous read and burst read tasks.
  assumes the device samples its pins on the 25 MHz block clock.
*/
`timescale 1ns/1ps
module fsw_host_model (
  input wire logic ref_clk_in, // device clock, used for pacing
  input wire logic [15:0] dq_in, // device data out
  input wire logic dq_oe_in, // device drives the bus
  output logic ce_n_out, // chip enable
  output logic oe_n_out, // output enable
  output logic we_n_out, // write enable
  output logic adv_n_out, // address valid
  output logic link_clk_out, // burst clock, still between frames
  output logic [15:0] dq_out // host data
);
  // pins idle high, link clock parked low
  initial begin
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    we_n_out = 1'b1;
    adv_n_out = 1'b1;
    link_clk_out = 1'b0;
    dq_out = 16'h0000;
  end

  //////////////////////////////////////////////////////////////////
  // command held through the low phase so the synchroniser sees it
  task automatic wr(input logic [7:0] cmd);
    @(posedge ref_clk_in) #1;
    ce_n_out = 1'b0;
    we_n_out = 1'b0;
    dq_out = {8'h00, cmd};
    repeat (4) @(posedge ref_clk_in);
    #1 we_n_out = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1 ce_n_out = 1'b1;
    dq_out = ~dq_out; // released bus must not keep the command
    repeat (6) @(posedge ref_clk_in);
    #1;
  endtask

  // bounded wait for the device to drive the bus
  task automatic wait_oe(output logic ok);
    int k;
    k = 0;
    while (dq_oe_in !== 1'b1 && k < 20) begin
      @(posedge ref_clk_in) #1;
      k++;
    end
    ok = (k < 20);
  endtask

  task automatic rd(output logic [15:0] w, output logic ok);
    @(posedge ref_clk_in) #1;
    ce_n_out = 1'b0;
    oe_n_out = 1'b0;
    wait_oe(ok);
    @(posedge ref_clk_in) #1;
    w = dq_in;
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    repeat (6) @(posedge ref_clk_in);
    #1;
  endtask

  // link clock runs only inside the frame
  task automatic burst(input int n, output logic [15:0] w [16], output logic ok);
    int k;
    @(posedge ref_clk_in) #1;
    ce_n_out = 1'b0;
    adv_n_out = 1'b0;
    oe_n_out = 1'b0;
    wait_oe(ok);
    adv_n_out = 1'b1;
    for (k = 0; k < n; k++) begin
      #160 link_clk_out = 1'b1;
      #160 link_clk_out = 1'b0;
      w[k] = dq_in;
    end
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    repeat (6) @(posedge ref_clk_in);
    #1;
  endtask
endmodule

// ### verification/fsw_status_tb.sv
/*
  self-checking bench for the status word block, driven through the
  host model's bus tasks and the engine event inputs.
  assumes the package constants and the designer's latencies.
*/
`timescale 1ns/1ps
module fsw_status_tb;
  import fsw_pkg::*;
  logic ref_clk, reset_n, ce_n, oe_n, we_n, adv_n, lclk, dq_oe, abort, eresume;
  logic sync_mode, seen, resumed, ok;
  logic [2:0] burst_len;
  logic [3:0] lv, ev;
  logic [7:0] sw;
  logic [15:0] dq_h, dq_d, bw [16];
  int n_mismatch, n_tests, i, j;
  localparam logic [3:0] EV_TAB [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  localparam logic [7:0] EV_SW [4] = '{8'h90, 8'hA0, 8'h88, 8'h82};
  localparam logic [7:0] LV_SW [4] = '{8'h00, 8'hC0, 8'h84, 8'h81};
  localparam logic [2:0] BL_TAB [3] = '{FSW_BL_4, FSW_BL_8, FSW_BL_16};

  fsw_host_model host (.ref_clk_in(ref_clk), .dq_in(dq_d), .dq_oe_in(dq_oe),
    .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n), .adv_n_out(adv_n),
    .link_clk_out(lclk), .dq_out(dq_h));
  fsw_status DUT (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .chip_enable_n_in(ce_n),
    .output_enable_n_in(oe_n), .write_enable_n_in(we_n), .address_valid_n_in(adv_n),
    .link_clk_in(lclk), .dq_in(dq_h), .sync_mode_in(sync_mode), .burst_len_in(burst_len),
    .array_data_in(16'h5A3C), .busy_in(lv[3]), .erase_susp_in(lv[2]),
    .prog_susp_in(lv[1]), .prog_err_in(ev[3]), .erase_err_in(ev[2]), .vpp_low_in(ev[1]),
    .locked_hit_in(ev[0]), .factory_load_in(lv[0]), .dq_out(dq_d), .dq_oe_out(dq_oe),
    .flash_status_word_out(sw), .abort_out(abort), .erase_resume_out(eresume));

  //////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // resume pulse lasts one cycle, so latch it
  always @(posedge ref_clk) begin
    if (eresume === 1'b1) resumed = 1'b1;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input string what, input logic [15:0] exp);
    logic [15:0] w;
    host.rd(w, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    chk(what, exp, w);
  endtask

  task automatic sw_chk(input logic [7:0] exp);
    repeat (4) @(posedge ref_clk);
    #1 chk("status word", {8'h00, exp}, {8'h00, sw});
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk) #1;
    ev = m;
    @(posedge ref_clk) #1;
    ev = 4'h0;
  endtask

  //////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    sync_mode = 1'b0;
    burst_len = FSW_BL_4;
    lv = 4'h0;
    ev = 4'h0;
    resumed = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    sw_chk(8'h80);
    host.wr(FSW_CMD_READ_STATUS);
    rd_chk("status read", 16'h0080);
    // each fresh enable fall must show the engine level now
    for (i = 0; i < 4; i++) begin
      lv = EV_TAB[i];
      rd_chk("level status", {8'h00, LV_SW[i]});
      lv = 4'h0;
      rd_chk("level gone", 16'h0080);
    end
    for (i = 0; i < 4; i++) begin
      pulse(EV_TAB[i]);
      // abort already stands when pulse returns, so start from it
      seen = (abort === 1'b1);
      repeat (3) @(posedge ref_clk) #1 seen |= abort;
      chk("abort", 16'h0001, {15'h0, seen});
      repeat (8) @(posedge ref_clk);
      rd_chk("error status", {8'h00, EV_SW[i]});
      host.wr(FSW_CMD_CLEAR_STATUS);
      host.wr(FSW_CMD_READ_STATUS);
      rd_chk("cleared", 16'h0080);
    end
    // sequence error inside erase suspend, then resume
    lv = 4'h4;
    host.wr(FSW_CMD_LOCK_SETUP);
    host.wr(FSW_CMD_READ_ARRAY);
    sw_chk(8'hF0);
    resumed = 1'b0;
    host.wr(FSW_CMD_CONFIRM);
    lv = 4'h8;
    chk("resume", 16'h0001, {15'h0, resumed});
    sw_chk(8'hB0);
    host.wr(FSW_CMD_CLEAR_STATUS);
    sw_chk(8'h00);
    lv = 4'h0;
    host.wr(FSW_CMD_READ_ARRAY);
    rd_chk("array", 16'h5A3C);
    host.wr(FSW_CMD_WORD_PROG);
    host.wr(8'h12);
    rd_chk("auto status", 16'h0080);
    // erase and lock sequences enter status too; a valid lock is no error
    host.wr(FSW_CMD_READ_ARRAY);
    host.wr(FSW_CMD_ERASE_SETUP);
    host.wr(FSW_CMD_CONFIRM);
    rd_chk("erase status", 16'h0080);
    host.wr(FSW_CMD_READ_ARRAY);
    host.wr(FSW_CMD_LOCK_SETUP);
    host.wr(FSW_CMD_LOCK);
    rd_chk("lock status", 16'h0080);
    pulse(4'h8);
    repeat (4) @(posedge ref_clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    sw_chk(8'h80);
    host.wr(FSW_CMD_READ_STATUS);
    lv = 4'h1;
    sync_mode = 1'b1;
    for (i = 0; i < 3; i++) begin
      burst_len = BL_TAB[i];
      host.burst(4 << i, bw, ok);
      chk("burst ready", 16'h0001, {15'h0, ok});
      if (ok !== 1'b1) wrap_up();
      for (j = 0; j < (4 << i); j++) chk("burst word", 16'h0081, bw[j]);
    end
    wrap_up();
  end
endmodule
